// ---- lrc_pkg.sv ----
// constants and types shared by the loader run/reset command handler
// How it works
// - run packet: length 7, sum, code, address
// - run address arrives most significant byte first
// - valid run branches to address, no reset
// - run acknowledge sent before branching
// - reset packet: length 3, sum, code
// - reset acknowledge sent before device reset
// - reset command performs full device reset
// - sum is modulo-256 of data bytes
// - good packet 0xcc, bad packet 0x33
// - leading zero bytes are skipped
// - first data byte is command code
package lrc_pkg;
   localparam logic [7:0] RUN_LEN = 8'h07;
   localparam logic [7:0] RST_LEN = 8'h03;
   localparam logic [7:0] CMD_RUN_CODE = 8'h22;
   localparam logic [7:0] CMD_RST_CODE = 8'h25;
   localparam logic [7:0] REPLY_ACK = 8'hcc;
   localparam logic [7:0] REPLY_NAK = 8'h33;
   localparam logic [7:0] IDLE_BYTE = 8'h00;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;

   typedef enum logic [4:0] {
      LRC_HUNT = 5'b00001,
      LRC_SUM = 5'b00010,
      LRC_DATA = 5'b00100,
      LRC_REPLY = 5'b01000,
      LRC_ACT = 5'b10000
   } lrc_state_t;
endpackage

// ---- lrc_sum_acc.sv ----
// running modulo-256 checksum over the data bytes of one packet
`timescale 1ns/100ps
module lrc_sum_acc (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic add_en,
   input wire logic [7:0] add_byte,
   output logic [7:0] sum
);
   typedef struct packed {
      logic [7:0] acc;
   } lrc_acc_t;
   lrc_acc_t st_q;
   lrc_acc_t st_d;

   // modulo sum; carries out of bit 7 are dropped on purpose
   always_comb begin
      st_d = st_q;
      if (clear) begin
         st_d.acc = 8'h00;
      end else if (add_en) begin
         st_d.acc = st_q.acc + add_byte;
      end
   end

   // running total register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sum = st_q.acc;
endmodule

// ---- lrc_cmd.sv ----
// run and reset command interpreter for the serial loader
`timescale 1ns/100ps
module lrc_cmd (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   output logic run_go,
   output logic [31:0] run_addr,
   output logic dev_reset_req,
   output logic pkt_other
);
   // whole walk state in one bank, so one register process holds it all
   typedef struct packed {
      lrc_pkg::lrc_state_t state;
      logic [7:0] len;
      logic [7:0] sum_rx;
      logic [7:0] idx;
      logic [7:0] cmd;
      logic [31:0] addr;
      logic good;
      logic [7:0] reply;
      logic go;
      logic rst;
      logic other;
   } lrc_st_t;
   lrc_st_t st_q;
   lrc_st_t st_d;
   logic [7:0] sum;
   logic sum_clear;
   logic sum_add;

   ////////////////////////////////////////////////////////////////////////
   // checksum accumulator over data bytes only
   lrc_sum_acc u_lrc_sum_acc (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clear(sum_clear),
      .add_en(sum_add),
      .add_byte(rx_byte),
      .sum(sum)
   );

   // length and sum bytes never reach the accumulator
   assign sum_clear = (st_q.state == lrc_pkg::LRC_HUNT);
   assign sum_add = (st_q.state == lrc_pkg::LRC_DATA) && rx_valid;

   ////////////////////////////////////////////////////////////////////////
   // packet walk: hunt, sum, data, reply, act
   always_comb begin
      st_d = st_q;
      st_d.go = 1'b0;
      st_d.rst = 1'b0;
      st_d.other = 1'b0;
      case (st_q.state)
         lrc_pkg::LRC_HUNT: begin
            // zero padding before a packet is skipped
            if (rx_valid && rx_byte != lrc_pkg::IDLE_BYTE) begin
               st_d.len = rx_byte;
               st_d.idx = 8'h00;
               st_d.state = lrc_pkg::LRC_SUM;
            end
         end
         lrc_pkg::LRC_SUM: begin
            if (rx_valid) begin
               st_d.sum_rx = rx_byte;
               // a length below 3 carries no command; answer it negatively
               if (st_q.len < 8'h03) begin
                  st_d.good = 1'b0;
                  st_d.reply = lrc_pkg::REPLY_NAK;
                  st_d.state = lrc_pkg::LRC_REPLY;
               end else begin
                  st_d.state = lrc_pkg::LRC_DATA;
               end
            end
         end
         lrc_pkg::LRC_DATA: begin
            if (rx_valid) begin
               // first data byte is the command code
               if (st_q.idx == 8'h00) begin
                  st_d.cmd = rx_byte;
               end else begin
                  // shift in address, most significant byte first
                  st_d.addr = {st_q.addr[23:0], rx_byte};
               end
               st_d.idx = st_q.idx + 8'h01;
               if (st_q.idx + 8'h03 == st_q.len) begin
                  st_d.good = ((sum + rx_byte) == st_q.sum_rx);
                  st_d.reply = ((sum + rx_byte) == st_q.sum_rx) ?
                     lrc_pkg::REPLY_ACK : lrc_pkg::REPLY_NAK;
                  st_d.state = lrc_pkg::LRC_REPLY;
               end
            end
         end
         lrc_pkg::LRC_REPLY: begin
            // action waits until the reply byte is taken
            if (tx_ready) begin
               st_d.state = st_q.good ? lrc_pkg::LRC_ACT : lrc_pkg::LRC_HUNT;
            end
         end
         lrc_pkg::LRC_ACT: begin
            st_d.state = lrc_pkg::LRC_HUNT;
            // run only with matching length and code, no reset
            if (st_q.cmd == lrc_pkg::CMD_RUN_CODE && st_q.len == lrc_pkg::RUN_LEN) begin
               st_d.go = 1'b1;
            end else if (st_q.cmd == lrc_pkg::CMD_RST_CODE && st_q.len == lrc_pkg::RST_LEN) begin
               st_d.rst = 1'b1;
            end else begin
               st_d.other = 1'b1; // left to the other loader commands
            end
         end
         default: begin
            st_d.state = lrc_pkg::LRC_HUNT;
         end
      endcase
   end

   // reset drops any half packet and any pending reply
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '{state: lrc_pkg::LRC_HUNT, addr: lrc_pkg::ADDR_RST, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign tx_valid = (st_q.state == lrc_pkg::LRC_REPLY);
   assign tx_byte = st_q.reply;
   assign run_go = st_q.go;
   assign run_addr = st_q.addr;
   assign dev_reset_req = st_q.rst;
   assign pkt_other = st_q.other;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // run only after ack taken; accept edge, then act state, then pulse
   AST_RUN_AFTER_ACK: assert property (run_go |->
      $past(tx_valid && tx_ready && tx_byte == lrc_pkg::REPLY_ACK, 2))
      else $error("run without prior ack");
   AST_RST_AFTER_ACK: assert property (dev_reset_req |->
      $past(tx_valid && tx_ready && tx_byte == lrc_pkg::REPLY_ACK, 2))
      else $error("reset without prior ack");
   AST_NO_BOTH: assert property (!(run_go && dev_reset_req))
      else $error("run and reset together");
   AST_NAK_NO_ACT: assert property (
      tx_valid && tx_ready && tx_byte == lrc_pkg::REPLY_NAK |=>
      (!run_go && !dev_reset_req) ##1 (!run_go && !dev_reset_req))
      else $error("acted after nak");
   AST_REPLY_CODES: assert property (
      tx_valid |-> tx_byte == lrc_pkg::REPLY_ACK || tx_byte == lrc_pkg::REPLY_NAK)
      else $error("bad reply byte");
   AST_ZERO_SKIP: assert property (
      st_q.state == lrc_pkg::LRC_HUNT && rx_valid && rx_byte == lrc_pkg::IDLE_BYTE |=>
      st_q.state == lrc_pkg::LRC_HUNT)
      else $error("zero not skipped");
   AST_RUN_CODE: assert property (
      run_go |-> st_q.cmd == lrc_pkg::CMD_RUN_CODE && st_q.len == lrc_pkg::RUN_LEN)
      else $error("run on wrong packet");
   AST_RST_CODE: assert property (
      dev_reset_req |-> st_q.cmd == lrc_pkg::CMD_RST_CODE && st_q.len == lrc_pkg::RST_LEN)
      else $error("reset on wrong packet");
   AST_ADDR_STABLE: assert property (run_go |-> $stable(run_addr))
      else $error("address moved at run");
   AST_ACK_SUM: assert property (
      st_q.state == lrc_pkg::LRC_DATA && rx_valid && st_q.idx + 8'h03 == st_q.len &&
      (sum + rx_byte) != st_q.sum_rx |=> tx_valid && tx_byte == lrc_pkg::REPLY_NAK)
      else $error("bad sum acked");
   AST_ACK_GOOD: assert property (
      st_q.state == lrc_pkg::LRC_DATA && rx_valid && st_q.idx + 8'h03 == st_q.len &&
      (sum + rx_byte) == st_q.sum_rx |=> tx_valid && tx_byte == lrc_pkg::REPLY_ACK)
      else $error("good sum refused");
   AST_SHORT_NAK: assert property (
      st_q.state == lrc_pkg::LRC_SUM && rx_valid && st_q.len < lrc_pkg::RST_LEN |=>
      tx_valid && tx_byte == lrc_pkg::REPLY_NAK)
      else $error("short packet acked");
   // reply holds until taken; a slow link must not lose it
   AST_REPLY_HOLD: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("reply dropped before taken");
   AST_NO_EARLY: assert property (
      tx_valid |-> !run_go && !dev_reset_req)
      else $error("action while reply pending");
   // good ack leads to one action
   AST_ACT_AFTER_ACK: assert property (
      tx_valid && tx_ready && tx_byte == lrc_pkg::REPLY_ACK |->
      ##2 (run_go || dev_reset_req || pkt_other))
      else $error("no action after ack");
   AST_RUN_PULSE: assert property (run_go |=> !run_go)
      else $error("run held");
   AST_RST_PULSE: assert property (dev_reset_req |=> !dev_reset_req)
      else $error("reset held");
   AST_CMD_FIRST: assert property (
      st_q.state == lrc_pkg::LRC_DATA && rx_valid && st_q.idx == 8'h00 |=>
      st_q.cmd == $past(rx_byte))
      else $error("command byte not taken");
   AST_ADDR_SHIFT: assert property (
      st_q.state == lrc_pkg::LRC_DATA && rx_valid && st_q.idx != 8'h00 |=>
      run_addr == {$past(run_addr[23:0]), $past(rx_byte)})
      else $error("address byte misplaced");

   // main scenarios: run, reset, refusal, other command, held reply
   COV_RUN: cover property (run_go);
   COV_RST: cover property (dev_reset_req);
   COV_NAK: cover property (tx_valid && tx_ready && tx_byte == lrc_pkg::REPLY_NAK);
   COV_OTHER: cover property (pkt_other);
   COV_HELD: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule

// ---- lrc_host_model.sv ----
// host side model that sends loader packets and takes the replies
`timescale 1ns/100ps
module lrc_host_model (
   input wire logic core_clk,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end
   ////////////////////////////////////////
   // one byte per falling edge, so bytes may run back to back
   task put(input logic [7:0] b);
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_byte = b;
   endtask
   // idle line flips, so a stale byte is never mistaken for data
   task idle();
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
   endtask
   task send(input logic [7:0] len, code, input logic [31:0] addr, input logic [7:0] bad);
      logic [7:0] s;
      s = code + addr[31:24] + addr[23:16] + addr[15:8] + addr[7:0];
      if (len != 8'h07) s = code;
      put(8'h00);
      put(8'h00);
      put(len);
      put(s ^ bad);
      put(code);
      if (len == 8'h07) for (int i = 3; i >= 0; i--)
         put(addr[i*8 +: 8]);
      idle();
   endtask
   // reply stands until taken; a slow host holds ready low a while
   task take(input int slow, output logic [7:0] r);
      int n;
      n = 0;
      while (tx_valid !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      repeat (slow) @(negedge core_clk);
      tx_ready = 1'b1;
      // reply only moves at a rising edge, so it is settled here and stands at the taking edge
      r = (tx_valid === 1'b1) ? tx_byte : 8'hxx;
      @(posedge core_clk);
      @(negedge core_clk);
      tx_ready = 1'b0;
   endtask
endmodule

// ---- tb_loader_run_reset_commands.sv ----
// self-checking bench for the loader run and reset command handler
`timescale 1ns/100ps
module tb_loader_run_reset_commands;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rx_valid, tx_valid, tx_ready, run_go, dev_reset_req, pkt_other;
   logic [7:0] rx_byte, tx_byte;
   logic [31:0] run_addr;
   int errors = 0;
   int check_count = 0;
   int n_run = 0, n_rst = 0, n_oth = 0, n_early = 0;
   always #25 core_clk = ~core_clk;
   lrc_cmd u_lrc_cmd (.core_clk(core_clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
      .run_go(run_go), .run_addr(run_addr), .dev_reset_req(dev_reset_req),
      .pkt_other(pkt_other));
   lrc_host_model u_lrc_host_model (.core_clk(core_clk), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
   ////////////////////////////////////////
   // tally pulses mid-cycle, where they are settled; one while the reply waits is too early
   always @(negedge core_clk) begin
      if (run_go === 1'b1) n_run++;
      if (dev_reset_req === 1'b1) n_rst++;
      if (pkt_other === 1'b1) n_oth++;
      if ((run_go | dev_reset_req) === 1'b1 && tx_valid === 1'b1) n_early++;
   end
   task chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         errors++;
         $display("Error %0t %s", $time, msg);
      end
   endtask
   // one packet, its reply and the pulses that follow it
   task cmd(input logic [7:0] len, code, input logic [31:0] addr, input logic [7:0] bad,
            input int slow, er, es, eo);
      logic [7:0] r;
      int a, b, c;
      a = n_run;
      b = n_rst;
      c = n_oth;
      u_lrc_host_model.send(len, code, addr, bad);
      u_lrc_host_model.take(slow, r);
      repeat (4) @(negedge core_clk);
      chk(r === (bad ? lrc_pkg::REPLY_NAK : lrc_pkg::REPLY_ACK), "reply byte");
      chk(n_run - a == er && n_rst - b == es && n_oth - c == eo, "action pulses");
      chk(n_early == 0, "action before reply");
   endtask
   task t_run();
      cmd(8'h07, lrc_pkg::CMD_RUN_CODE, 32'h8a3c_51f0, 8'h00, 3, 1, 0, 0);
      chk(run_addr === 32'h8a3c_51f0, "run address");
   endtask
   task t_rst();
      cmd(8'h03, lrc_pkg::CMD_RST_CODE, 32'h0, 8'h00, 0, 0, 1, 0);
   endtask
   task t_bad();
      cmd(8'h07, lrc_pkg::CMD_RUN_CODE, 32'h0000_1111, 8'h01, 1, 0, 0, 0);
      chk(run_addr === 32'h0000_1111, "address bytes landed");
      cmd(8'h03, lrc_pkg::CMD_RST_CODE, 32'h0, 8'h10, 0, 0, 0, 0);
   endtask
   task t_other();
      cmd(8'h03, 8'h20, 32'h0, 8'h00, 0, 0, 0, 1);
      cmd(8'h03, lrc_pkg::CMD_RUN_CODE, 32'h0, 8'h00, 0, 0, 0, 1);
      cmd(8'h02, lrc_pkg::CMD_RUN_CODE, 32'h0, 8'h01, 0, 0, 0, 0);
      cmd(8'h07, lrc_pkg::CMD_RUN_CODE, 32'h0102_0304, 8'h00, 0, 1, 0, 0);
      chk(run_addr === 32'h0102_0304, "byte order");
   endtask
   // a reset cut into a packet leaves nothing pending, and the next packet works
   task t_mid_reset();
      u_lrc_host_model.put(8'h07);
      u_lrc_host_model.put(8'h11);
      u_lrc_host_model.idle();
      sys_rst = 1'b1;
      repeat (2) @(negedge core_clk);
      chk(tx_valid === 1'b0 && run_addr === lrc_pkg::ADDR_RST, "values in reset");
      sys_rst = 1'b0;
      cmd(8'h03, lrc_pkg::CMD_RST_CODE, 32'h0, 8'h00, 0, 0, 1, 0);
   endtask
   ////////////////////////////////////////
   task report_and_stop();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      t_run();
      t_rst();
      t_bad();
      t_other();
      t_mid_reset();
      report_and_stop();
   end
   // the tests need about 140 cycles, so this only cuts a hang
   initial begin
      #(3000 * 50);
      errors++;
      report_and_stop();
   end
endmodule
